// *** sgcb_pkg.sv ***
package sgcb_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] STORM_HOST_CTRL_IDX = 8'h06;
    localparam logic [7:0] RESERVED_CTRL_IDX = 8'h08;
    localparam logic [7:0] LED_MODE_CTRL_IDX = 8'h0a;
    localparam logic [7:0] STORM_HOST_CTRL_ADDR = 8'(STORM_HOST_CTRL_IDX * 4);
    localparam logic [7:0] RESERVED_CTRL_ADDR = 8'(RESERVED_CTRL_IDX * 4);
    localparam logic [7:0] LED_MODE_CTRL_ADDR = 8'(LED_MODE_CTRL_IDX * 4);

    // Values after reset
    localparam logic [15:0] STORM_HOST_CTRL_RST = 16'h6300;
    localparam logic [15:0] RESERVED_CTRL_RST = 16'h2400;
    localparam logic [15:0] LED_MODE_CTRL_RST = 16'h0835;

    // Field positions
    localparam int RATE_LOW_MSB = 15;
    localparam int RATE_LOW_LSB = 8;
    localparam int HALF_DUPLEX_BIT = 6;
    localparam int FLOW_CTRL_BIT = 5;
    localparam int NULL_VID_BIT = 3;
    localparam int RATE_HIGH_MSB = 2;
    localparam int LED_SEL_HIGH_BIT = 15;
    localparam int LED_SEL_LOW_BIT = 9;

    // Storm counting period
    localparam int CLK_MHZ = 125;
    localparam int PERIOD_FAST_MS = 67;
    localparam int PERIOD_SLOW_MS = 670;
    localparam int PERIOD_FAST_CYCLES = PERIOD_FAST_MS * 1000 * CLK_MHZ;
    localparam int PERIOD_SLOW_CYCLES = PERIOD_SLOW_MS * 1000 * CLK_MHZ;
    localparam int PERIOD_W = 27;
    localparam int RATE_W = 11;
    localparam int PORT_COUNT = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {LED_LINKACT, LED_SPEEDSPLIT, LED_SEPARATE, LED_OFF} sgcb_led_e;

    // Per-port status and traffic from the switch core
    typedef struct packed {
        logic linkUp;
        logic activity;
        logic fullDuplex;
        logic collision;
        logic speed100;
        logic blockValid;
        logic destBroadcast;
        logic destMulticast;
    } sgcb_port_in_s;

    typedef struct packed {
        logic awDone;
        logic wDone;
        logic [7:0] awAddr;
        logic [15:0] wData;
        logic [1:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [1:0] rResp;
        logic [15:0] rData;
        logic [15:0] stormHostCtrl;
        logic [15:0] reservedCtrl;
        logic [15:0] ledModeCtrl;
        logic [PORT_COUNT-1:0][PERIOD_W-1:0] period;
        logic [PORT_COUNT-1:0][RATE_W-1:0] blockCount;
        logic [PORT_COUNT-1:0] limitHit;
        logic [PORT_COUNT-1:0] stormDiscard;
        logic [11:0] vidOut;
        logic [PORT_COUNT-1:0][3:0] indicator;
    } sgcb_state_s;
endpackage

// *** sgcb_switch_global_control.sv ***
`timescale 1ns/1ns
module sgcb_switch_global_control
    import sgcb_pkg::*;
#(
    parameter int PERIOD_FAST = PERIOD_FAST_CYCLES,
    parameter int PERIOD_SLOW = PERIOD_SLOW_CYCLES
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Switch core status and traffic
    input wire sgcb_port_in_s [PORT_COUNT-1:0] portIn,
    input wire logic multicastStormExclude,
    input wire logic [11:0] tagVidIn,
    input wire logic [11:0] portDefaultVid,
    // Controls to the switch core
    output logic hostHalfDuplex,
    output logic hostFlowControl,
    output logic [PORT_COUNT-1:0] stormLimitHit,
    output logic [PORT_COUNT-1:0] stormDiscard,
    output logic [11:0] tagVidOut,
    // Port indicators, active high
    output logic [PORT_COUNT-1:0] portIndicatorThree,
    output logic [PORT_COUNT-1:0] portIndicatorTwo,
    output logic [PORT_COUNT-1:0] portIndicatorOne,
    output logic [PORT_COUNT-1:0] portIndicatorZero
);
    localparam logic [PERIOD_W-1:0] FAST_LAST = PERIOD_W'(PERIOD_FAST - 1);
    localparam logic [PERIOD_W-1:0] SLOW_LAST = PERIOD_W'(PERIOD_SLOW - 1);

    sgcb_state_s st;
    sgcb_state_s next_st;
    logic doWrite;
    logic [RATE_W-1:0] threshold;
    logic [PORT_COUNT-1:0] stormClass;
    logic [PORT_COUNT-1:0] periodEnd;
    sgcb_led_e ledMode;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data,
                                          input logic [1:0] strb);
        merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction

    assign threshold = {st.stormHostCtrl[RATE_HIGH_MSB:0],
                        st.stormHostCtrl[RATE_LOW_MSB:RATE_LOW_LSB]};
    assign ledMode = sgcb_led_e'({st.ledModeCtrl[LED_SEL_HIGH_BIT],
                                  st.ledModeCtrl[LED_SEL_LOW_BIT]});
    assign doWrite = st.awDone & st.wDone & ~st.bValid;

    always_comb
    begin
        logic linkAct;
        logic dupCol;
        linkAct = 1'b0;
        dupCol = 1'b0;
        next_st = st;
        stormClass = '0;
        periodEnd = '0;
        // Write path: address and data taken in either order
        if (s_axi_awvalid && !st.awDone && !st.bValid)
        begin
            next_st.awDone = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.wDone && !st.bValid)
        begin
            next_st.wDone = 1'b1;
            next_st.wData = s_axi_wdata[15:0];
            next_st.wStrb = s_axi_wstrb[1:0];
        end
        if (doWrite)
        begin
            next_st.awDone = 1'b0;
            next_st.wDone = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp = RESP_OKAY;
            if (st.awAddr[7:2] == STORM_HOST_CTRL_ADDR[7:2])
                next_st.stormHostCtrl = merge(st.stormHostCtrl, st.wData, st.wStrb);
            else if (st.awAddr[7:2] == RESERVED_CTRL_ADDR[7:2])
                next_st.reservedCtrl = merge(st.reservedCtrl, st.wData, st.wStrb);
            else if (st.awAddr[7:2] == LED_MODE_CTRL_ADDR[7:2])
                next_st.ledModeCtrl = merge(st.ledModeCtrl, st.wData, st.wStrb);
            else
                next_st.bResp = RESP_SLVERR;
        end
        else if (st.bValid && s_axi_bready)
            next_st.bValid = 1'b0;
        // Read path: one read outstanding, answered the cycle after acceptance
        if (s_axi_arvalid && !st.rValid)
        begin
            next_st.rValid = 1'b1;
            next_st.rResp = RESP_OKAY;
            if (s_axi_araddr[7:2] == STORM_HOST_CTRL_ADDR[7:2])
                next_st.rData = st.stormHostCtrl;
            else if (s_axi_araddr[7:2] == RESERVED_CTRL_ADDR[7:2])
                next_st.rData = st.reservedCtrl;
            else if (s_axi_araddr[7:2] == LED_MODE_CTRL_ADDR[7:2])
                next_st.rData = st.ledModeCtrl;
            else
            begin
                next_st.rData = '0;
                next_st.rResp = RESP_SLVERR;
            end
        end
        else if (st.rValid && s_axi_rready)
            next_st.rValid = 1'b0;
        // Storm counting per input port
        for (int p = 0; p < PORT_COUNT; p++)
        begin
            stormClass[p] = portIn[p].destBroadcast
                | (portIn[p].destMulticast & ~multicastStormExclude);
            periodEnd[p] = st.period[p] >= (portIn[p].speed100 ? FAST_LAST : SLOW_LAST);
            next_st.stormDiscard[p] = portIn[p].blockValid & stormClass[p]
                & (st.blockCount[p] >= threshold);
            if (periodEnd[p])
            begin
                next_st.period[p] = '0;
                next_st.blockCount[p] = '0;
            end
            else
            begin
                next_st.period[p] = st.period[p] + 1'b1;
                // Only admitted blocks count, so the count never wraps
                if (portIn[p].blockValid && stormClass[p] && st.blockCount[p] < threshold)
                    next_st.blockCount[p] = st.blockCount[p] + 1'b1;
            end
            next_st.limitHit[p] = next_st.blockCount[p] >= threshold;
            linkAct = portIn[p].linkUp & ~portIn[p].activity;
            dupCol = portIn[p].fullDuplex | portIn[p].collision;
            case (ledMode)
                LED_LINKACT:
                    next_st.indicator[p] = {1'b0, linkAct, dupCol, portIn[p].speed100};
                LED_SPEEDSPLIT:
                    next_st.indicator[p] = {1'b0, linkAct & portIn[p].speed100,
                                            linkAct & ~portIn[p].speed100,
                                            portIn[p].fullDuplex};
                LED_SEPARATE:
                    next_st.indicator[p] = {portIn[p].activity, portIn[p].linkUp, dupCol,
                                            portIn[p].speed100};
                default:
                    next_st.indicator[p] = 4'h0;
            endcase
        end
        // Null VID substitution on the tag path
        if (st.stormHostCtrl[NULL_VID_BIT] && tagVidIn == 12'h000)
            next_st.vidOut = portDefaultVid;
        else
            next_st.vidOut = tagVidIn;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st <= '0;
            st.stormHostCtrl <= STORM_HOST_CTRL_RST;
            st.reservedCtrl <= RESERVED_CTRL_RST;
            st.ledModeCtrl <= LED_MODE_CTRL_RST;
        end
        else
            st <= next_st;
    end

    assign s_axi_awready = ~st.awDone & ~st.bValid;
    assign s_axi_wready = ~st.wDone & ~st.bValid;
    assign s_axi_bvalid = st.bValid;
    assign s_axi_bresp = st.bResp;
    assign s_axi_arready = ~st.rValid;
    assign s_axi_rvalid = st.rValid;
    assign s_axi_rresp = st.rResp;
    assign s_axi_rdata = {16'h0000, st.rData};
    assign hostHalfDuplex = st.stormHostCtrl[HALF_DUPLEX_BIT];
    assign hostFlowControl = st.stormHostCtrl[FLOW_CTRL_BIT];
    assign stormLimitHit = st.limitHit;
    assign stormDiscard = st.stormDiscard;
    assign tagVidOut = st.vidOut;
    for (genvar g = 0; g < PORT_COUNT; g++)
    begin : g_led
        assign {portIndicatorThree[g], portIndicatorTwo[g], portIndicatorOne[g],
                portIndicatorZero[g]} = st.indicator[g];
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_thr_count;
        portIn[0].blockValid && stormClass[0] && !periodEnd[0] && st.blockCount[0] < threshold
            |=> st.blockCount[0] == $past(st.blockCount[0]) + 1'b1;
    endproperty
    a_thr_count: assert property (p_thr_count) else $error("admitted block not counted");

    property p_period_end;
        periodEnd[0] |=> st.blockCount[0] == '0 && st.period[0] == '0;
    endproperty
    a_period_end: assert property (p_period_end) else $error("period did not restart");

    property p_reset_value;
        $past(reset) |-> threshold == 11'h063 && !hostHalfDuplex && !hostFlowControl;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad value after reset");

    property p_half_duplex;
        doWrite && st.awAddr[7:2] == STORM_HOST_CTRL_ADDR[7:2] && st.wStrb[0]
            |=> hostHalfDuplex == $past(st.wData[HALF_DUPLEX_BIT]);
    endproperty
    a_half_duplex: assert property (p_half_duplex) else $error("half duplex not written");

    property p_flow_ctrl;
        doWrite && st.awAddr[7:2] == STORM_HOST_CTRL_ADDR[7:2] && st.wStrb[0]
            |=> hostFlowControl == $past(st.wData[FLOW_CTRL_BIT]);
    endproperty
    a_flow_ctrl: assert property (p_flow_ctrl) else $error("flow control not written");

    property p_null_vid;
        st.stormHostCtrl[NULL_VID_BIT] && tagVidIn == 12'h000
            |=> tagVidOut == $past(portDefaultVid);
    endproperty
    a_null_vid: assert property (p_null_vid) else $error("null VID not replaced");

    property p_led_split;
        ledMode == LED_SPEEDSPLIT |=> portIndicatorTwo[0]
            == $past(portIn[0].linkUp & ~portIn[0].activity & portIn[0].speed100);
    endproperty
    a_led_split: assert property (p_led_split) else $error("speed split LED wrong");

    property p_mcast_excl;
        multicastStormExclude && portIn[0].blockValid && !portIn[0].destBroadcast
            && !periodEnd[0] |=> st.blockCount[0] == $past(st.blockCount[0]);
    endproperty
    a_mcast_excl: assert property (p_mcast_excl) else $error("excluded multicast counted");

    property p_discard;
        portIn[0].blockValid && stormClass[0] && st.blockCount[0] >= threshold
            |=> stormDiscard[0] ##0 stormLimitHit[0] || $past(periodEnd[0]);
    endproperty
    a_discard: assert property (p_discard) else $error("storm block not discarded");
endmodule

// *** tb_sgcb_switch_global_control.sv ***
`timescale 1ns/1ns
module tb_sgcb_switch_global_control
    import sgcb_pkg::*;
;
    logic clk_sys = 1'b0, reset = 1'b1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    sgcb_port_in_s [PORT_COUNT-1:0] portIn = '0;
    logic multicastStormExclude = 1'b0;
    logic [11:0] tagVidIn = '0, portDefaultVid = '0, tagVidOut;
    logic hostHalfDuplex, hostFlowControl;
    logic [PORT_COUNT-1:0] stormLimitHit, stormDiscard;
    logic [PORT_COUNT-1:0] portIndicatorThree, portIndicatorTwo, portIndicatorOne;
    logic [PORT_COUNT-1:0] portIndicatorZero;
    int n_errors = 0, compares = 0;
    int discCnt [PORT_COUNT] = '{default: 0};
    // Indicator nibble per mode, link up, full duplex, 100M, no collision; activity, then idle
    logic [3:0] ledExp [8] = '{4'h3, 4'h1, 4'hf, 4'h0, 4'h7, 4'h5, 4'h7, 4'h0};

    sgcb_switch_global_control #(.PERIOD_FAST(40), .PERIOD_SLOW(400)) dut (
        .clk_sys(clk_sys), .reset(reset),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .portIn(portIn),
        .multicastStormExclude(multicastStormExclude), .tagVidIn(tagVidIn),
        .portDefaultVid(portDefaultVid), .hostHalfDuplex(hostHalfDuplex),
        .hostFlowControl(hostFlowControl), .stormLimitHit(stormLimitHit),
        .stormDiscard(stormDiscard), .tagVidOut(tagVidOut),
        .portIndicatorThree(portIndicatorThree), .portIndicatorTwo(portIndicatorTwo),
        .portIndicatorOne(portIndicatorOne), .portIndicatorZero(portIndicatorZero));

    always #4 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
        for (int p = 0; p < PORT_COUNT; p++)
            if (stormDiscard[p] === 1'b1)
                discCnt[p]++;

    task automatic close_out;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [15:0] ctrl(input logic [10:0] thr, input logic hd, fc, nv);
        return {thr[7:0], 1'b0, hd, fc, 1'b0, nv, thr[10:8]};
    endfunction

    task automatic axi_write(input logic [7:0] a, input logic [15:0] d, input logic [1:0] rsp);
        logic awPend = 1'b1;
        logic wPend = 1'b1;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (awPend || wPend)
        begin
            @(posedge clk_sys);
            if (awPend && s_axi_awready === 1'b1)
            begin
                awPend = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (wPend && s_axi_wready === 1'b1)
            begin
                wPend = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1)
            @(posedge clk_sys);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, rsp, "bresp");
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, d, "rdata");
        chk(s_axi_rresp, rsp, "rresp");
    endtask

    task automatic send_blocks(input int p, input int n, input logic bc, input logic mc);
        repeat (n)
        begin
            @(posedge clk_sys);
            portIn[p].blockValid <= 1'b1;
            portIn[p].destBroadcast <= bc;
            portIn[p].destMulticast <= mc;
        end
        @(posedge clk_sys);
        portIn[p].blockValid <= 1'b0;
    endtask

    // Hit the limit, then wait for its fall so the next period starts fresh
    task automatic sync_period(input int p);
        for (int i = 0; i < 500 && stormLimitHit[p] !== 1'b1; i++)
            send_blocks(p, 1, 1'b1, 1'b0);
        while (stormLimitHit[p] === 1'b1)
            @(posedge clk_sys);
    endtask

    task automatic storm_case(input int p, input bit doSync, input logic bc, input logic mc,
                              input int expDisc, input logic expHit);
        int d0;
        if (doSync)
            sync_period(p);
        d0 = discCnt[p];
        send_blocks(p, 5, bc, mc);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(discCnt[p] - d0, expDisc, "discards");
        chk(stormLimitHit[p], expHit, "limit hit");
    endtask

    task automatic vid_case(input logic [11:0] vin, input logic [11:0] expVid);
        @(posedge clk_sys);
        tagVidIn <= vin;
        portDefaultVid <= 12'h5a5;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(tagVidOut, expVid, "vid");
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        close_out();
    end

    initial
    begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        portIn[0].linkUp <= 1'b1;
        portIn[0].activity <= 1'b1;
        portIn[0].fullDuplex <= 1'b1;
        portIn[0].speed100 <= 1'b1;
        @(negedge clk_sys);
        chk(hostHalfDuplex, 1'b0, "half duplex");
        chk(hostFlowControl, 1'b0, "flow control");
        axi_read(STORM_HOST_CTRL_ADDR, 32'h0000_6300, RESP_OKAY);
        axi_read(RESERVED_CTRL_ADDR, 32'h0000_2400, RESP_OKAY);
        axi_read(LED_MODE_CTRL_ADDR, {16'h0000, LED_MODE_CTRL_RST}, RESP_OKAY);
        axi_read(8'h30, 32'h0000_0000, RESP_SLVERR);
        axi_write(8'h30, 16'hffff, RESP_SLVERR);
        axi_write(STORM_HOST_CTRL_ADDR, ctrl(11'h003, 1'b1, 1'b1, 1'b1), RESP_OKAY);
        axi_read(STORM_HOST_CTRL_ADDR, {16'h0000, ctrl(11'h003, 1'b1, 1'b1, 1'b1)},
                 RESP_OKAY);
        @(negedge clk_sys);
        chk(hostHalfDuplex, 1'b1, "half duplex");
        chk(hostFlowControl, 1'b1, "flow control");
        vid_case(12'h000, 12'h5a5);
        vid_case(12'h123, 12'h123);
        storm_case(0, 1, 1'b1, 1'b0, 2, 1'b1);
        repeat (40) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(stormLimitHit[0], 1'b0, "fast period end");
        @(posedge clk_sys);
        multicastStormExclude <= 1'b1;
        storm_case(0, 1, 1'b0, 1'b1, 0, 1'b0);
        @(posedge clk_sys);
        multicastStormExclude <= 1'b0;
        storm_case(0, 1, 1'b0, 1'b1, 2, 1'b1);
        sync_period(1);
        send_blocks(1, 4, 1'b1, 1'b0);
        repeat (300) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(stormLimitHit[1], 1'b1, "slow period hold");
        repeat (110) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(stormLimitHit[1], 1'b0, "slow period end");
        axi_write(STORM_HOST_CTRL_ADDR, ctrl(11'h103, 1'b0, 1'b0, 1'b0), RESP_OKAY);
        storm_case(0, 0, 1'b1, 1'b0, 0, 1'b0);
        @(negedge clk_sys);
        chk(hostHalfDuplex, 1'b0, "full duplex");
        chk(hostFlowControl, 1'b0, "flow off");
        vid_case(12'h000, 12'h000);
        // Second pass drops activity so the link/activity indicators light
        for (int m = 0; m < 8; m++)
        begin
            @(posedge clk_sys);
            portIn[0].activity <= ~m[2];
            axi_write(LED_MODE_CTRL_ADDR, LED_MODE_CTRL_RST | {m[1], 5'h00, m[0], 9'h000},
                      RESP_OKAY);
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            chk({portIndicatorThree[0], portIndicatorTwo[0], portIndicatorOne[0],
                 portIndicatorZero[0]}, ledExp[m], "led");
        end
        close_out();
    end
endmodule
